//--- core/abu_defs.vh
`ifndef ABU_DEFS_VH
`define ABU_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define ABU_IDX_WAIT_STATUS   16'hFE00
`define ABU_IDX_RESERVED      16'hFE02
`define ABU_IDX_FLAG_CONTROL  16'hFE03
`define ABU_IDX_ADDR_HIGH     16'hFE09
`define ABU_IDX_ADDR_LOW      16'hFE0A
`define ABU_IDX_STATUS_CTRL   16'hFE0B
`define ABU_IDX_EVENT_STATUS  16'hFE10
`define ABU_IDX_EVENT_MASK    16'hFE11

// Field positions.
`define ABU_BIT_ENABLE        7
`define ABU_BIT_ACTIVE        6
`define ABU_BIT_WAIT_EXIT     1
`define ABU_BIT_FLAG_CLEAR    7
`define ABU_EVT_BREAK         0
`define ABU_EVT_WAIT_EXIT     1
`define ABU_EVT_SOFT          2
`define ABU_EVT_COUNT         3

// Reset values.
`define ABU_RST_BYTE          8'h00
`define ABU_RST_ADDR          16'h0000
`define ABU_RST_EVENTS        3'h0

// Break vectors for normal and monitor operation.
`define ABU_VEC_NORMAL        16'hFFFC
`define ABU_VEC_MONITOR       16'hFEFC

// Bus answer latency in wait cycles.
`define ABU_BUS_WAIT_CYCLES   1

`endif

//--- core/abu_avs.v
`timescale 1ns/1ps
// Avalon-MM handshake: every access is held for exactly one wait cycle.
module abu_avs (
	input  wire ref_clk,
	input  wire rst,
	input  wire avs_read,
	input  wire avs_write,
	output wire avs_waitrequest,
	output wire acc_rd_prep,
	output wire acc_wr
);

	reg ack_r;
	wire ack_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// The single wait cycle gives the register file time to latch read data.
	assign ack_nxt         = (avs_read | avs_write) & ~ack_r;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign acc_rd_prep     = avs_read & ~ack_r;
	assign acc_wr          = avs_write & ack_r;   // Takes effect at the accepting edge.

	// Acknowledge flop; it drops after one cycle so back-to-back requests pace at two.
	always @(posedge ref_clk) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
		end
	end

endmodule // abu_avs

//--- core/abu_sticky.v
`timescale 1ns/1ps
// Sticky event bits with write-one-to-clear and a masked interrupt level.
module abu_sticky #(
	parameter N = 3
) (
	input  wire         ref_clk,
	input  wire         rst,
	input  wire [N-1:0] evt_set,
	input  wire [N-1:0] evt_clr,
	input  wire [N-1:0] evt_mask,
	output wire [N-1:0] evt_status,
	output wire         evt_irq
);

	reg [N-1:0] status_r;

	////////////////////////////////////////////////////////////////////////////////
	// One flop per event; a set in the same cycle as a clear wins so no event is lost.
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			always @(posedge ref_clk) begin
				if (rst) begin
					status_r[i] <= 1'b0;
				end else begin
					status_r[i] <= evt_set[i] | (status_r[i] & ~evt_clr[i]);
				end
			end
		end
	endgenerate

	// Level output while any unmasked bit stands.
	assign evt_status = status_r;
	assign evt_irq    = |(status_r & evt_mask);

endmodule // abu_sticky

//--- core/abu_core.v
// Behaviour
// - A CPU address equal to the programmed break address raises a breakpoint request.
// - A break makes the CPU load a software interrupt opcode and vector to FFFC or FEFC.
// - Writing one to the active bit raises a break just before the next instruction.
// - The break state ends when the break routine executes a return from interrupt.
// - A match on an opcode address breaks before that instruction executes.
// - A match on an operand address lets the instruction finish before the break.
// - With the address left unchanged after a break, no further match break occurs.
// - The status/control register holds enable in bit 7, active in bit 6, zeros below.
// - The wait status flag sits in bit 1, resets to zero and clears on a written zero.
// - The flag control register holds flag-clear-enable in bit 7; the reserved slot reads 0.
// - An address match breaks only while the enable bit is set; writing zero clears it.
// - A match sets the active bit, and software clears it with a zero before leaving.
// - In the break state other status flags are clearable only with flag-clear-enable set.
// - The wait flag reads one when a break caused the exit from wait mode.
`timescale 1ns/1ps
`include "abu_defs.vh"
module abu_core #(
	parameter AW = 16
) (
	input  wire          ref_clk,
	input  wire          rst,
	input  wire [AW-1:0] avs_address,
	input  wire          avs_read,
	input  wire          avs_write,
	input  wire [31:0]   avs_writedata,
	input  wire [3:0]    avs_byteenable,
	output wire [31:0]   avs_readdata,
	output wire          avs_waitrequest,
	input  wire [15:0]   cpu_addr,
	input  wire          cpu_addr_valid,
	input  wire          cpu_opcode_fetch,
	input  wire          cpu_instr_boundary,
	input  wire          cpu_return_from_interrupt,
	input  wire          cpu_in_wait,
	input  wire          monitor_mode,
	output wire          breakpoint_request,
	output wire          software_interrupt_opcode_load,
	output wire [15:0]   break_vector,
	output wire          break_state,
	output wire          flag_clear_allowed,
	output wire          irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	reg  [15:0] brk_addr_r;
	reg         brk_enable_r;
	reg         brk_active_r;
	reg         brk_armed_r;
	reg         brk_pending_r;
	reg         brk_state_r;
	reg         wait_exit_r;
	reg         flag_clear_en_r;
	reg         breakpoint_request_r;
	reg  [15:0] vector_r;
	reg  [31:0] rdata_r;
	reg  [`ABU_EVT_COUNT-1:0] evt_mask_r;

	reg  [15:0] brk_addr_nxt;
	reg         brk_enable_nxt;
	reg         brk_active_nxt;
	reg         brk_armed_nxt;
	reg         brk_pending_nxt;
	reg         brk_state_nxt;
	reg         wait_exit_nxt;
	reg         flag_clear_en_nxt;
	reg  [`ABU_EVT_COUNT-1:0] evt_mask_nxt;
	reg  [7:0]  rd_byte;

	wire        acc_rd_prep;
	wire        acc_wr;
	wire        lane0_wr;
	wire [7:0]  wbyte;
	wire        addr_hit;
	wire        match_ok;
	wire        hit_opcode;
	wire        hit_operand;
	wire        sw_break;
	wire        fire;
	wire [`ABU_EVT_COUNT-1:0] evt_set;
	wire [`ABU_EVT_COUNT-1:0] evt_clr;
	wire [`ABU_EVT_COUNT-1:0] evt_status;

	// Register select; used by both the read multiplexer and the write decode.
	function sel;
		input [AW-1:0] addr;
		input [15:0]   idx;
		begin
			sel = (addr == idx[AW-1:0]);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake and write strobe.

	abu_avs u_avs (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_waitrequest (avs_waitrequest),
		.acc_rd_prep     (acc_rd_prep),
		.acc_wr          (acc_wr)
	);

	// Registers are one byte wide, so only the lowest byte lane carries writes.
	assign lane0_wr = acc_wr & avs_byteenable[0];
	assign wbyte    = avs_writedata[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// Address comparison and break timing.

	// Qualified match: enabled, armed by a fresh address, and no break already active.
	assign addr_hit    = cpu_addr_valid & (cpu_addr == brk_addr_r);
	assign match_ok    = addr_hit & brk_enable_r & brk_armed_r & ~brk_active_r;
	assign hit_opcode  = match_ok & cpu_opcode_fetch;
	assign hit_operand = match_ok & ~cpu_opcode_fetch;
	assign sw_break    = lane0_wr & sel(avs_address, `ABU_IDX_STATUS_CTRL)
		& wbyte[`ABU_BIT_ACTIVE] & ~brk_active_r;

	// An opcode hit fires at once so the fetched instruction is replaced; pending
	// operand and software breaks wait for the next instruction boundary.
	// Limitation: an opcode hit inside the break state disarms the comparator but
	// raises no request, because the routine's own fetches must never nest a break.
	assign fire = ~brk_state_r & (hit_opcode | (brk_pending_r & cpu_instr_boundary));

	// Pending break request, held until an instruction boundary releases it.
	always @* begin
		brk_pending_nxt = brk_pending_r;
		if (fire) begin
			brk_pending_nxt = 1'b0;
		end else if (hit_operand | sw_break) begin
			brk_pending_nxt = 1'b1;
		end
	end

	// Break state runs from the request until the routine returns.
	always @* begin
		brk_state_nxt = brk_state_r;
		if (fire) begin
			brk_state_nxt = 1'b1;
		end else if (brk_state_r & cpu_return_from_interrupt) begin
			brk_state_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register write side.

	// Break address bytes; a write re-arms the comparator.
	always @* begin
		brk_addr_nxt  = brk_addr_r;
		brk_armed_nxt = brk_armed_r;
		if (match_ok) begin
			brk_armed_nxt = 1'b0;
		end
		if (lane0_wr & sel(avs_address, `ABU_IDX_ADDR_HIGH)) begin
			brk_addr_nxt[15:8] = wbyte;
			brk_armed_nxt      = 1'b1;
		end
		if (lane0_wr & sel(avs_address, `ABU_IDX_ADDR_LOW)) begin
			brk_addr_nxt[7:0] = wbyte;
			brk_armed_nxt     = 1'b1;
		end
	end

	// Enable and active bits; a hardware match beats a software clear of active.
	always @* begin
		brk_enable_nxt = brk_enable_r;
		brk_active_nxt = brk_active_r;
		if (lane0_wr & sel(avs_address, `ABU_IDX_STATUS_CTRL)) begin
			brk_enable_nxt = wbyte[`ABU_BIT_ENABLE];
			brk_active_nxt = wbyte[`ABU_BIT_ACTIVE];
		end
		if (match_ok) begin
			brk_active_nxt = 1'b1;
		end
	end

	// Wait-exit flag and flag-clear-enable; the wait flag clears only on a written 0.
	always @* begin
		wait_exit_nxt     = wait_exit_r;
		flag_clear_en_nxt = flag_clear_en_r;
		if (lane0_wr & sel(avs_address, `ABU_IDX_WAIT_STATUS) & ~wbyte[`ABU_BIT_WAIT_EXIT]) begin
			wait_exit_nxt = 1'b0;
		end
		if (fire & cpu_in_wait) begin
			wait_exit_nxt = 1'b1;
		end
		if (lane0_wr & sel(avs_address, `ABU_IDX_FLAG_CONTROL)) begin
			flag_clear_en_nxt = wbyte[`ABU_BIT_FLAG_CLEAR];
		end
	end

	// Event mask register.
	always @* begin
		evt_mask_nxt = evt_mask_r;
		if (lane0_wr & sel(avs_address, `ABU_IDX_EVENT_MASK)) begin
			evt_mask_nxt = wbyte[`ABU_EVT_COUNT-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read side.

	// Reserved and unmapped locations read zero, so software sees a stable answer.
	always @* begin
		rd_byte = `ABU_RST_BYTE;
		if (sel(avs_address, `ABU_IDX_WAIT_STATUS)) begin
			rd_byte[`ABU_BIT_WAIT_EXIT] = wait_exit_r;
		end else if (sel(avs_address, `ABU_IDX_FLAG_CONTROL)) begin
			rd_byte[`ABU_BIT_FLAG_CLEAR] = flag_clear_en_r;
		end else if (sel(avs_address, `ABU_IDX_ADDR_HIGH)) begin
			rd_byte = brk_addr_r[15:8];
		end else if (sel(avs_address, `ABU_IDX_ADDR_LOW)) begin
			rd_byte = brk_addr_r[7:0];
		end else if (sel(avs_address, `ABU_IDX_STATUS_CTRL)) begin
			rd_byte[`ABU_BIT_ENABLE] = brk_enable_r;
			rd_byte[`ABU_BIT_ACTIVE] = brk_active_r;
		end else if (sel(avs_address, `ABU_IDX_EVENT_STATUS)) begin
			rd_byte[`ABU_EVT_COUNT-1:0] = evt_status;
		end else if (sel(avs_address, `ABU_IDX_EVENT_MASK)) begin
			rd_byte[`ABU_EVT_COUNT-1:0] = evt_mask_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt events.

	assign evt_set[`ABU_EVT_BREAK]     = fire;
	assign evt_set[`ABU_EVT_WAIT_EXIT] = fire & cpu_in_wait;
	assign evt_set[`ABU_EVT_SOFT]      = sw_break;
	assign evt_clr = (lane0_wr & sel(avs_address, `ABU_IDX_EVENT_STATUS))
		? wbyte[`ABU_EVT_COUNT-1:0] : `ABU_RST_EVENTS;

	abu_sticky #(
		.N (`ABU_EVT_COUNT)
	) u_sticky (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.evt_set    (evt_set),
		.evt_clr    (evt_clr),
		.evt_mask   (evt_mask_r),
		.evt_status (evt_status),
		.evt_irq    (irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// State registers.

	// Everything clears on reset except brk_armed_r, which sets, and vector_r, which loads FFFC; the reserved slot has no storage and reads zero.
	always @(posedge ref_clk) begin
		if (rst) begin
			brk_addr_r      <= `ABU_RST_ADDR;
			brk_enable_r    <= 1'b0;
			brk_active_r    <= 1'b0;
			brk_armed_r     <= 1'b1;
			brk_pending_r   <= 1'b0;
			brk_state_r     <= 1'b0;
			wait_exit_r     <= 1'b0;
			flag_clear_en_r <= 1'b0;
			evt_mask_r      <= `ABU_RST_EVENTS;
			breakpoint_request_r          <= 1'b0;
			vector_r        <= `ABU_VEC_NORMAL;
			rdata_r         <= 32'h00000000;
		end else begin
			brk_addr_r      <= brk_addr_nxt;
			brk_enable_r    <= brk_enable_nxt;
			brk_active_r    <= brk_active_nxt;
			brk_armed_r     <= brk_armed_nxt;
			brk_pending_r   <= brk_pending_nxt;
			brk_state_r     <= brk_state_nxt;
			wait_exit_r     <= wait_exit_nxt;
			flag_clear_en_r <= flag_clear_en_nxt;
			evt_mask_r      <= evt_mask_nxt;
			breakpoint_request_r          <= fire;
			vector_r        <= monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL;
			// Read data is captured in the wait cycle and holds until the next read.
			if (acc_rd_prep) begin
				rdata_r <= {24'h000000, rd_byte};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs toward the integration logic and the bus.

	// The request pulse also tells the integration logic to substitute the opcode.
	assign breakpoint_request             = breakpoint_request_r;
	assign software_interrupt_opcode_load = breakpoint_request_r;
	assign break_vector                   = vector_r;
	assign break_state                    = brk_state_r;
	// Other modules may clear their flags outside the break state, or inside it when enabled.
	assign flag_clear_allowed             = ~brk_state_r | flag_clear_en_r;
	assign avs_readdata                   = rdata_r;

endmodule // abu_core

//--- verif/abu_core_asserts.sv
`timescale 1ns/1ps
`include "abu_defs.vh"
// Port-level watch of the break unit; the comparator is out of sight, so each check
// ties a handshake, pulse or state output to its cause.
module abu_core_asserts (
	input wire        ref_clk,
	input wire        rst,
	input wire        avs_read,
	input wire        avs_write,
	input wire        avs_waitrequest,
	input wire [31:0] avs_readdata,
	input wire        cpu_return_from_interrupt,
	input wire        monitor_mode,
	input wire        breakpoint_request,
	input wire        software_interrupt_opcode_load,
	input wire [15:0] break_vector,
	input wire        break_state,
	input wire        flag_clear_allowed
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	chk_bus_first_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("bus answered without a wait");
	chk_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait longer than one cycle");
	chk_rd_high_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_req_one_cycle: assert property (breakpoint_request |=> !breakpoint_request)
		else $error("break request longer than one cycle");
	chk_swi_load_pair: assert property (software_interrupt_opcode_load == breakpoint_request)
		else $error("opcode load differs from request");
	chk_vector_select: assert property (!$past(rst) |-> break_vector ==
		($past(monitor_mode) ? `ABU_VEC_MONITOR : `ABU_VEC_NORMAL))
		else $error("wrong break vector");
	chk_req_enters_break: assert property (breakpoint_request |-> break_state)
		else $error("request without break state");
	chk_rti_ends_break: assert property (break_state && cpu_return_from_interrupt |=> !break_state)
		else $error("break state survives return");
	chk_break_holds: assert property (break_state && !cpu_return_from_interrupt |=> break_state)
		else $error("break state dropped early");
	chk_no_nested_req: assert property ($past(break_state) |-> !breakpoint_request)
		else $error("request inside break state");
	chk_flag_open: assert property (!break_state |-> flag_clear_allowed)
		else $error("flag clearing blocked outside break");
endmodule // abu_core_asserts

bind abu_core abu_core_asserts u_chk (.ref_clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
	.avs_readdata, .cpu_return_from_interrupt, .monitor_mode, .breakpoint_request,
	.software_interrupt_opcode_load, .break_vector, .break_state, .flag_clear_allowed);

//--- verif/abu_cpu_model.sv
`timescale 1ns/1ps
// CPU side of the break link: each call is one bus cycle of the given kind.
module abu_cpu_model (
	input  wire         ref_clk,
	output logic [15:0] cpu_addr = 16'h0000,
	output logic        cpu_addr_valid = 1'b0,
	output logic        cpu_opcode_fetch = 1'b0,
	output logic        cpu_instr_boundary = 1'b0,
	output logic        cpu_return_from_interrupt = 1'b0
);
	// Kind bits are valid, opcode, boundary, return. The idle cycle after shows the
	// inverted address, so a stale match on a released bus cannot pass unseen.
	task automatic drive(input logic [15:0] a, input logic [3:0] k);
		@(posedge ref_clk);
		cpu_addr <= a;
		{cpu_addr_valid, cpu_opcode_fetch, cpu_instr_boundary, cpu_return_from_interrupt} <= k;
		@(posedge ref_clk);
		cpu_addr <= ~a;
		{cpu_addr_valid, cpu_opcode_fetch, cpu_instr_boundary, cpu_return_from_interrupt} <= 4'h0;
	endtask
endmodule // abu_cpu_model

//--- verif/tb_abu_core.sv
`timescale 1ns/1ps
// Self-checking bench for the address breakpoint unit.
module tb_abu_core;
	localparam logic W = 1'b1, R = 1'b0;
	logic        ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic        cpu_in_wait = 1'b0, monitor_mode = 1'b0;
	logic [15:0] avs_address = 16'h0000, a, exp_bk[$];
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [7:0]  rnd = 8'h3A, exp_rd[$];
	wire  [31:0] avs_readdata;
	wire  [15:0] cpu_addr, break_vector;
	wire         avs_waitrequest, cpu_addr_valid, cpu_opcode_fetch, cpu_instr_boundary, irq;
	wire         cpu_return_from_interrupt, breakpoint_request, software_interrupt_opcode_load;
	wire         break_state, flag_clear_allowed;
	int          n_mismatch = 0, check_count = 0, cycles = 0;

	abu_core u_abu_core (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_addr, .cpu_addr_valid,
		.cpu_opcode_fetch, .cpu_instr_boundary, .cpu_return_from_interrupt, .cpu_in_wait,
		.monitor_mode, .breakpoint_request, .software_interrupt_opcode_load, .break_vector,
		.break_state, .flag_clear_allowed, .irq);
	abu_cpu_model u_cpu (.ref_clk, .cpu_addr, .cpu_addr_valid, .cpu_opcode_fetch,
		.cpu_instr_boundary, .cpu_return_from_interrupt);

	// 25 MHz clock.
	initial forever #20 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Levels are read one edge after the cause, once its updates have landed.
	task automatic lvl(input logic [2:0] e);
		@(posedge ref_clk);
		chk({29'h0, break_state, flag_clear_allowed, irq}, {29'h0, e});
	endtask
	// One Avalon access held until waitrequest is sampled low; a read notes d as expected.
	task automatic bus(input logic w, input logic [15:0] adr, input logic [7:0] d);
		@(posedge ref_clk);
		avs_address <= adr;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		if (!w) exp_rd.push_back(d);
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wrap_up;
		if (exp_rd.size() || exp_bk.size()) n_mismatch++;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Results are matched in order against the notes; an unnoted break is a mismatch.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 3000) begin
			n_mismatch++;
			wrap_up;
		end
		if (avs_read && avs_waitrequest === 1'b0)
			chk(avs_readdata, exp_rd.size() ? {24'h0, exp_rd.pop_front()} : 32'hX);
		if (breakpoint_request !== 1'b0)
			chk({16'h0, break_vector}, exp_bk.size() ? {16'h0, exp_bk.pop_front()} : 32'hX);
	end
	// Main sequence.
	initial begin
		static logic [15:0] idx[9] = '{16'hFE00, 16'hFE02, 16'hFE03, 16'hFE09, 16'hFE0A,
			16'hFE0B, 16'hFE10, 16'hFE11, 16'hFE05};
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (idx[i]) bus(R, idx[i], 8'h00);
		rnd = lfsr(rnd);
		a[15:8] = rnd;
		rnd = lfsr(rnd);
		a[7:0] = rnd;
		bus(W, 16'hFE09, a[15:8]);
		bus(W, 16'hFE0A, a[7:0]);
		bus(R, 16'hFE09, a[15:8]);
		bus(R, 16'hFE0A, a[7:0]);
		bus(W, 16'hFE02, 8'hFF);
		bus(R, 16'hFE02, 8'h00);
		bus(W, 16'hFE03, 8'hFF);
		bus(R, 16'hFE03, 8'h80);
		bus(W, 16'hFE03, 8'h00);
		bus(W, 16'hFE0B, 8'h3F);
		bus(R, 16'hFE0B, 8'h00);
		// A write with the low byte lane off must leave the register alone.
		avs_byteenable <= 4'hE;
		bus(W, 16'hFE0B, 8'h80);
		avs_byteenable <= 4'hF;
		bus(R, 16'hFE0B, 8'h00);
		u_cpu.drive(a, 4'hC);
		bus(W, 16'hFE0A, a[7:0]);
		bus(W, 16'hFE11, 8'h07);
		bus(W, 16'hFE0B, 8'h80);
		exp_bk.push_back(16'hFFFC);
		u_cpu.drive(a, 4'hC);
		u_cpu.drive(a, 4'hC);
		lvl(3'b101);
		bus(R, 16'hFE0B, 8'hC0);
		bus(W, 16'hFE03, 8'h80);
		lvl(3'b111);
		bus(W, 16'hFE03, 8'h00);
		bus(R, 16'hFE10, 8'h01);
		bus(W, 16'hFE11, 8'h00);
		lvl(3'b100);
		bus(W, 16'hFE11, 8'h07);
		bus(W, 16'hFE10, 8'h01);
		lvl(3'b100);
		// Leaving the address unchanged must not break again after return.
		bus(W, 16'hFE0B, 8'h80);
		u_cpu.drive(16'h0000, 4'h1);
		lvl(3'b010);
		u_cpu.drive(a, 4'hC);
		rnd = lfsr(rnd);
		a[7:0] = rnd;
		bus(W, 16'hFE0A, a[7:0]);
		monitor_mode <= 1'b1;
		exp_bk.push_back(16'hFEFC);
		u_cpu.drive(a, 4'hC);
		bus(W, 16'hFE0B, 8'h80);
		u_cpu.drive(16'h0000, 4'h1);
		monitor_mode <= 1'b0;
		// An operand match waits for the instruction to finish.
		bus(W, 16'hFE09, a[15:8]);
		u_cpu.drive(a, 4'h8);
		repeat (3) @(posedge ref_clk);
		exp_bk.push_back(16'hFFFC);
		u_cpu.drive(16'h0000, 4'h2);
		bus(W, 16'hFE0B, 8'h80);
		u_cpu.drive(16'h0000, 4'h1);
		// A software break taken while waiting also flags the wait exit.
		cpu_in_wait <= 1'b1;
		bus(W, 16'hFE0B, 8'hC0);
		repeat (3) @(posedge ref_clk);
		exp_bk.push_back(16'hFFFC);
		u_cpu.drive(16'h0000, 4'h2);
		cpu_in_wait <= 1'b0;
		bus(R, 16'hFE00, 8'h02);
		bus(W, 16'hFE00, 8'h00);
		bus(R, 16'hFE00, 8'h00);
		bus(R, 16'hFE10, 8'h07);
		bus(W, 16'hFE0B, 8'h80);
		u_cpu.drive(16'h0000, 4'h1);
		repeat (3) @(posedge ref_clk);
		wrap_up;
	end
endmodule // tb_abu_core
